/* File: rtl/emi_ctrl.sv */
// External data memory interface controller: routing, sequencing, pins
// Notes on behaviour
// - Muxed mode shares low address and data pins
// - Interface drives its own address latch strobe
// - Latch strobe high while low address shown
// - Latch strobe falls, then pins carry data
// - Non-muxed mode uses separate address pins
// - Internal mode: all moves on-chip, 8 kB wrap
// - Short move address is page then index, outside external mode
// - Wide move uses full data pointer
// - Split modes: below boundary on-chip, else off
// - Split no-bank: short move leaves high byte
// - Split wide move drives all sixteen lines
// - Split bank: short move drives page high
// - External mode: every move goes off-chip
// - External short move: page ignored, high undriven
// - External wide move drives all sixteen lines
// - Setup, hold, strobe, latch widths programmable
// - Off-chip move lasts settings plus four
// - Shortest non-muxed off-chip move five cycles
// - Muxed adds latch cycles, seven minimum
// - Setup and hold reset to maximum
// - Multiplex select zero muxed, one separate
// - Latch high and low one to four
// - Strobe width is field plus one
// - Setup and hold equal their codes
`timescale 1ns/10ps
`include "emi_map.svh"
module emi_ctrl (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        NRST_IN,
    // Configuration load and readback
    input  wire logic        CFG_LOAD_IN,
    input  wire logic [7:0]  CFG_BYTE_IN,
    input  wire logic        TIMING_LOAD_IN,
    input  wire logic [7:0]  TIMING_BYTE_IN,
    input  wire logic [7:0]  PAGE_HIGH_BYTE_IN,
    output logic [7:0]       CFG_BYTE_OUT,
    output logic [7:0]       TIMING_BYTE_OUT,
    // CPU move request and answer
    input  wire logic        REQ_IN,
    input  wire logic        WRITE_IN,
    input  wire logic        WIDE_IN,
    input  wire logic [15:0] DPTR_IN,
    input  wire logic [7:0]  INDEX_IN,
    input  wire logic [7:0]  WDATA_IN,
    output logic             BUSY_OUT,
    output logic             DONE_OUT,
    output logic [7:0]       RDATA_OUT,
    output emi_pkg::emi_phase_t PHASE_OUT,
    // On-chip RAM port
    output logic             RAM_EN_OUT,
    output logic             RAM_WE_OUT,
    output logic [12:0]      RAM_ADDR_OUT,
    output logic [7:0]       RAM_WDATA_OUT,
    input  wire logic [7:0]  RAM_RDATA_IN,
    // External memory port pins
    output logic [7:0]       ADDR_HI_OUT,
    output logic             ADDR_HI_OE_OUT,
    output logic [7:0]       ADDR_LO_OUT,
    output logic             ADDR_LO_OE_OUT,
    input  wire logic [7:0]  AD_IN,
    output logic [7:0]       AD_OUT,
    output logic             AD_OE_OUT,
    output logic             ALE_OUT,
    output logic             RD_N_OUT,
    output logic             WR_N_OUT
);
    import emi_pkg::*;

    // ****************************************************************
    // Reset state
    // ****************************************************************
    localparam emi_state_t RST_STATE = '{
        phase:               EMI_IDLE,
        multiplex_select:    `EMI_RST_MUX,
        memory_map_mode:     `EMI_RST_MODE,
        latch_pulse_width:   `EMI_RST_ALE,
        address_setup_field: `EMI_RST_SETUP,
        address_hold_field:  `EMI_RST_HOLD,
        strobe_width_field:  `EMI_RST_STROBE,
        rd_n:                1'b1,
        wr_n:                1'b1,
        default:             '0
    };

    emi_state_t  state_ff;
    emi_state_t  nxt_state;
    logic [15:0] route_addr;
    logic        route_offchip;
    logic        route_hi_drive;

    // ****************************************************************
    // Address routing
    // ****************************************************************

    // Decode of the move now offered by the CPU
    emi_route u_route (
        .mode_in      (state_ff.memory_map_mode),
        .wide_in      (WIDE_IN),
        .dptr_in      (DPTR_IN),
        .index_in     (INDEX_IN),
        .page_in      (PAGE_HIGH_BYTE_IN),
        .eff_addr_out (route_addr),
        .offchip_out  (route_offchip),
        .hi_drive_out (route_hi_drive)
    );

    // ****************************************************************
    // Phase helpers
    // ****************************************************************

    // Cycles spent in a phase; zero means the phase is skipped
    function automatic logic [4:0] phase_len(input emi_phase_t p, input emi_state_t s);
        logic [4:0] len;
        len = 5'h01;
        case (p)
            EMI_ALE_HI, EMI_ALE_LO: begin
                if (s.multiplex_select == `EMI_MUX_SEPARATE) begin
                    len = 5'h00;
                end else begin
                    len = {3'h0, s.latch_pulse_width} + 5'h01;
                end
            end
            EMI_SETUP: begin
                len = {3'h0, s.address_setup_field};
            end
            EMI_STROBE: begin
                len = {1'b0, s.strobe_width_field} + 5'h01;
            end
            EMI_HOLD: begin
                len = {3'h0, s.address_hold_field};
            end
            default: begin
                len = 5'h01;
            end
        endcase
        return len;
    endfunction : phase_len

    // Plain successor of an off-chip phase
    function automatic emi_phase_t succ(input emi_phase_t p);
        emi_phase_t n;
        n = EMI_DONE;
        case (p)
            EMI_ADDR:   n = EMI_ALE_HI;
            EMI_ALE_HI: n = EMI_ALE_LO;
            EMI_ALE_LO: n = EMI_PRE;
            EMI_PRE:    n = EMI_SETUP;
            EMI_SETUP:  n = EMI_STROBE;
            EMI_STROBE: n = EMI_HOLD;
            EMI_HOLD:   n = EMI_POST;
            default:    n = EMI_DONE;
        endcase
        return n;
    endfunction : succ

    // Next phase with nonzero length; at most two are skipped in a row
    function automatic emi_phase_t after(input emi_phase_t p, input emi_state_t s);
        emi_phase_t n;
        n = succ(p);
        for (int i = 0; i < 2; i++) begin
            if (phase_len(n, s) == 5'h00) begin
                n = succ(n);
            end
        end
        return n;
    endfunction : after

    // Phases in which the external port is owned by a move
    function automatic logic is_ext(input emi_phase_t p);
        return (p == EMI_ADDR) || (p == EMI_ALE_HI) || (p == EMI_ALE_LO) ||
               (p == EMI_PRE) || (p == EMI_SETUP) || (p == EMI_STROBE) ||
               (p == EMI_HOLD) || (p == EMI_POST);
    endfunction : is_ext

    // Phases in which muxed pins still carry the low address
    function automatic logic is_addr(input emi_phase_t p);
        return (p == EMI_ADDR) || (p == EMI_ALE_HI) || (p == EMI_ALE_LO);
    endfunction : is_addr

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;

        // Configuration loads, only between moves
        if (state_ff.phase == EMI_IDLE) begin
            if (CFG_LOAD_IN) begin
                nxt_state.multiplex_select  = CFG_BYTE_IN[`EMI_CFG_MUX_BIT];
                nxt_state.memory_map_mode   = CFG_BYTE_IN[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO];
                nxt_state.latch_pulse_width = CFG_BYTE_IN[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO];
            end
            if (TIMING_LOAD_IN) begin
                nxt_state.address_setup_field =
                    TIMING_BYTE_IN[`EMI_TC_SETUP_HI:`EMI_TC_SETUP_LO];
                nxt_state.strobe_width_field  =
                    TIMING_BYTE_IN[`EMI_TC_STROBE_HI:`EMI_TC_STROBE_LO];
                nxt_state.address_hold_field  =
                    TIMING_BYTE_IN[`EMI_TC_HOLD_HI:`EMI_TC_HOLD_LO];
            end
        end

        // Phase sequencing
        case (state_ff.phase)
            EMI_IDLE: begin
                if (REQ_IN) begin
                    nxt_state.write    = WRITE_IN;
                    nxt_state.wdata    = WDATA_IN;
                    nxt_state.addr     = route_addr;
                    nxt_state.hi_drive = route_hi_drive;
                    nxt_state.cnt      = 5'h00;
                    if (route_offchip) begin
                        nxt_state.phase = EMI_ADDR;
                    end else begin
                        nxt_state.phase = EMI_RAM;
                    end
                end
            end
            EMI_RAM: begin
                nxt_state.phase = EMI_RAM_DONE;
            end
            EMI_RAM_DONE: begin
                nxt_state.phase = EMI_IDLE;
                if (!state_ff.write) begin
                    nxt_state.rdata = RAM_RDATA_IN;
                end
            end
            EMI_DONE: begin
                nxt_state.phase = EMI_IDLE;
            end
            default: begin
                // Count down the phase, then enter the next nonempty one
                if (state_ff.cnt != 5'h00) begin
                    nxt_state.cnt = state_ff.cnt - 5'h01;
                end else begin
                    nxt_state.phase = after(state_ff.phase, state_ff);
                    nxt_state.cnt   = phase_len(nxt_state.phase, state_ff) - 5'h01;
                end
            end
        endcase

        // Read data taken at the last strobe cycle
        if ((state_ff.phase == EMI_STROBE) && (state_ff.cnt == 5'h00) && !state_ff.write) begin
            nxt_state.rdata = AD_IN;
        end

        // Completion pulse
        nxt_state.done = (nxt_state.phase == EMI_DONE) ||
                         (state_ff.phase == EMI_RAM_DONE);

        // Strobes follow the phase being entered
        nxt_state.ale  = (nxt_state.phase == EMI_ALE_HI);
        nxt_state.rd_n = !((nxt_state.phase == EMI_STROBE) && !nxt_state.write);
        nxt_state.wr_n = !((nxt_state.phase == EMI_STROBE) && nxt_state.write);

        // Shared pins: low address first, then data
        if ((nxt_state.multiplex_select != `EMI_MUX_SEPARATE) && is_addr(nxt_state.phase)) begin
            nxt_state.ad_out = nxt_state.addr[7:0];
            nxt_state.ad_oe  = 1'b1;
        end else if (is_ext(nxt_state.phase)) begin
            nxt_state.ad_out = nxt_state.wdata;
            nxt_state.ad_oe  = nxt_state.write;
        end else begin
            nxt_state.ad_oe  = 1'b0;
        end

        // Separate address pins
        nxt_state.addr_lo_oe = is_ext(nxt_state.phase) &&
                               (nxt_state.multiplex_select == `EMI_MUX_SEPARATE);
        nxt_state.addr_hi_oe = is_ext(nxt_state.phase) &&
                               nxt_state.hi_drive;

        // On-chip RAM strobe
        nxt_state.ram_en = (nxt_state.phase == EMI_RAM);
        nxt_state.ram_we = (nxt_state.phase == EMI_RAM) && nxt_state.write;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_ff <= RST_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Configuration readback, unused bits zero
    assign CFG_BYTE_OUT    = {3'h0, state_ff.multiplex_select,
                              state_ff.memory_map_mode, state_ff.latch_pulse_width};
    assign TIMING_BYTE_OUT = {state_ff.address_setup_field, state_ff.strobe_width_field,
                              state_ff.address_hold_field};

    // CPU answer
    assign BUSY_OUT  = (state_ff.phase != EMI_IDLE);
    assign DONE_OUT  = state_ff.done;
    assign RDATA_OUT = state_ff.rdata;
    assign PHASE_OUT = state_ff.phase;

    // On-chip RAM, address wraps at the populated size
    assign RAM_EN_OUT    = state_ff.ram_en;
    assign RAM_WE_OUT    = state_ff.ram_we;
    assign RAM_ADDR_OUT  = state_ff.addr[`EMI_RAM_AW-1:0];
    assign RAM_WDATA_OUT = state_ff.wdata;

    // External pins
    assign ADDR_HI_OUT    = state_ff.addr[15:8];
    assign ADDR_HI_OE_OUT = state_ff.addr_hi_oe;
    assign ADDR_LO_OUT    = state_ff.addr[7:0];
    assign ADDR_LO_OE_OUT = state_ff.addr_lo_oe;
    assign AD_OUT         = state_ff.ad_out;
    assign AD_OE_OUT      = state_ff.ad_oe;
    assign ALE_OUT        = state_ff.ale;
    assign RD_N_OUT       = state_ff.rd_n;
    assign WR_N_OUT       = state_ff.wr_n;

endmodule : emi_ctrl

/* File: rtl/emi_map.svh */
// Constants of the external memory interface: fields, codes, reset values
`ifndef EMI_MAP_SVH
`define EMI_MAP_SVH

// ****************************************************************
// Configuration byte field positions
// ****************************************************************
`define EMI_CFG_MUX_BIT     4
`define EMI_CFG_MODE_HI     3
`define EMI_CFG_MODE_LO     2
`define EMI_CFG_ALE_HI      1
`define EMI_CFG_ALE_LO      0

// ****************************************************************
// Timing byte field positions
// ****************************************************************
`define EMI_TC_SETUP_HI     7
`define EMI_TC_SETUP_LO     6
`define EMI_TC_STROBE_HI    5
`define EMI_TC_STROBE_LO    2
`define EMI_TC_HOLD_HI      1
`define EMI_TC_HOLD_LO      0

// ****************************************************************
// Reset values of the fields
// ****************************************************************
`define EMI_RST_MUX         1'h0
`define EMI_RST_MODE        2'h0
`define EMI_RST_ALE         2'h3
`define EMI_RST_SETUP       2'h3
`define EMI_RST_STROBE      4'hf
`define EMI_RST_HOLD        2'h3

// ****************************************************************
// Memory map mode codes and address limits
// ****************************************************************
`define EMI_MODE_INTERNAL   2'h0
`define EMI_MODE_SPLIT_NB   2'h1
`define EMI_MODE_SPLIT_B    2'h2
`define EMI_MODE_EXTERNAL   2'h3
`define EMI_MUX_SEPARATE    1'h1
`define EMI_ONCHIP_LIMIT    16'h2000
`define EMI_RAM_AW          13

`endif

/* File: rtl/emi_pkg.sv */
// Types shared by the external memory interface modules
package emi_pkg;

    // Access phases, in the order an off-chip move walks them
    typedef enum logic [3:0] {
        EMI_IDLE,
        EMI_RAM,
        EMI_RAM_DONE,
        EMI_ADDR,
        EMI_ALE_HI,
        EMI_ALE_LO,
        EMI_PRE,
        EMI_SETUP,
        EMI_STROBE,
        EMI_HOLD,
        EMI_POST,
        EMI_DONE
    } emi_phase_t;

    // Whole state of the controller
    typedef struct packed {
        emi_phase_t  phase;
        logic [4:0]  cnt;
        logic        multiplex_select;
        logic [1:0]  memory_map_mode;
        logic [1:0]  latch_pulse_width;
        logic [1:0]  address_setup_field;
        logic [3:0]  strobe_width_field;
        logic [1:0]  address_hold_field;
        logic        write;
        logic        hi_drive;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        done;
        logic        ale;
        logic        rd_n;
        logic        wr_n;
        logic [7:0]  ad_out;
        logic        ad_oe;
        logic        addr_hi_oe;
        logic        addr_lo_oe;
        logic        ram_en;
        logic        ram_we;
    } emi_state_t;

endpackage : emi_pkg

/* File: rtl/emi_route.sv */
// Effective address and on-chip or off-chip routing of a move
`timescale 1ns/10ps
`include "emi_map.svh"
module emi_route (
    // Mode and move kind
    input  wire logic [1:0]  mode_in,
    input  wire logic        wide_in,
    // Address sources
    input  wire logic [15:0] dptr_in,
    input  wire logic [7:0]  index_in,
    input  wire logic [7:0]  page_in,
    // Routing result
    output logic [15:0]      eff_addr_out,
    output logic             offchip_out,
    output logic             hi_drive_out
);
    import emi_pkg::*;

    logic [15:0] paged;
    logic        below;

    // Page forms the high byte of a short move outside external mode
    assign paged = {page_in, index_in};

    // Decision address for short and wide moves
    always_comb begin
        eff_addr_out = wide_in ? dptr_in : paged;
        below        = eff_addr_out < `EMI_ONCHIP_LIMIT;
        offchip_out  = 1'b0;
        hi_drive_out = 1'b0;
        if (mode_in == `EMI_MODE_INTERNAL) begin
            offchip_out = 1'b0;
        end else if (mode_in == `EMI_MODE_SPLIT_NB) begin
            offchip_out  = !below;
            hi_drive_out = wide_in;
        end else if (mode_in == `EMI_MODE_SPLIT_B) begin
            offchip_out  = !below;
            hi_drive_out = 1'b1;
        end else begin
            offchip_out  = 1'b1;
            hi_drive_out = wide_in;
            if (!wide_in) begin
                eff_addr_out = {8'h00, index_in};
            end
        end
    end

endmodule : emi_route

/* File: dv/emi_ctrl_props.sv */
// Checker of strobe, latch and pin relations of the memory interface
`timescale 1ns/10ps
module emi_ctrl_props (
    // Clock and reset
    input wire logic       CLK_IN,
    input wire logic       NRST_IN,
    // Watched outputs
    input wire logic [7:0] CFG_BYTE_OUT,
    input wire logic [7:0] TIMING_BYTE_OUT,
    input wire logic       DONE_OUT,
    input wire logic       RAM_EN_OUT,
    input wire logic       ADDR_LO_OE_OUT,
    input wire logic       AD_OE_OUT,
    input wire logic       ALE_OUT,
    input wire logic       RD_N_OUT,
    input wire logic       WR_N_OUT
);
    logic [4:0] stb_ff;
    logic [4:0] ale_ff;
    logic       stb;
    assign stb = !(RD_N_OUT && WR_N_OUT);
    // Cycles spent so far in the strobe and in latch high
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            stb_ff <= 5'h0;
            ale_ff <= 5'h0;
        end else begin
            stb_ff <= stb ? stb_ff + 5'h1 : 5'h0;
            ale_ff <= ALE_OUT ? ale_ff + 5'h1 : 5'h0;
        end
    end
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    chk_ale_muxed: assert property (ALE_OUT |-> !CFG_BYTE_OUT[4])
        else $error("latch strobe in separate mode");
    chk_lo_pins_mux: assert property (!CFG_BYTE_OUT[4] |-> !ADDR_LO_OE_OUT)
        else $error("low address pins driven in muxed mode");
    chk_lo_pins_sep: assert property (stb && CFG_BYTE_OUT[4] |-> ADDR_LO_OE_OUT)
        else $error("low address pins idle in separate mode");
    chk_strobe_no_ale: assert property (stb |-> !ALE_OUT && (RD_N_OUT || WR_N_OUT))
        else $error("strobe overlaps latch strobe or other strobe");
    chk_read_release: assert property (!RD_N_OUT |-> !AD_OE_OUT)
        else $error("data pins driven during read");
    chk_write_drive: assert property (!WR_N_OUT |-> AD_OE_OUT)
        else $error("data pins released during write");
    chk_ale_hold: assert property ($fell(ALE_OUT) |-> AD_OE_OUT)
        else $error("address dropped as latch strobe fell");
    chk_ram_answer: assert property (RAM_EN_OUT |=> !DONE_OUT ##1 DONE_OUT)
        else $error("on-chip move answer late or early");
    chk_ext_no_ram: assert property (CFG_BYTE_OUT[3:2] == 2'h3 |-> !RAM_EN_OUT)
        else $error("on-chip access in external mode");
    chk_strobe_width: assert property (!stb && $past(stb) |->
        stb_ff == {1'b0, TIMING_BYTE_OUT[5:2]} + 5'h1)
        else $error("strobe width wrong");
    chk_ale_width: assert property ($fell(ALE_OUT) |->
        ale_ff == {3'h0, CFG_BYTE_OUT[1:0]} + 5'h1)
        else $error("latch strobe width wrong");
    cov_ram: cover property (RAM_EN_OUT);
    cov_ale: cover property (ALE_OUT && AD_OE_OUT);
    cov_sep_write: cover property (!WR_N_OUT && CFG_BYTE_OUT[4]);
endmodule : emi_ctrl_props

bind emi_ctrl emi_ctrl_props u_props (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CFG_BYTE_OUT(CFG_BYTE_OUT),
    .TIMING_BYTE_OUT(TIMING_BYTE_OUT), .DONE_OUT(DONE_OUT), .RAM_EN_OUT(RAM_EN_OUT),
    .ADDR_LO_OE_OUT(ADDR_LO_OE_OUT), .AD_OE_OUT(AD_OE_OUT), .ALE_OUT(ALE_OUT),
    .RD_N_OUT(RD_N_OUT), .WR_N_OUT(WR_N_OUT)
);

/* File: dv/emi_sram_model.sv */
// Off-chip asynchronous memory with transparent address latch
`timescale 1ns/10ps
module emi_sram_model #(
    parameter logic [7:0] PORT_HI = 8'h00
) (
    // Clock and wiring choice
    input  wire logic        clk_in,
    input  wire logic        mux_in,
    // Pins from the interface
    input  wire logic        ale_in,
    input  wire logic        rd_n_in,
    input  wire logic        wr_n_in,
    input  wire logic [7:0]  ad_pins_in,
    input  wire logic [7:0]  addr_hi_in,
    input  wire logic        addr_hi_oe_in,
    input  wire logic [7:0]  addr_lo_in,
    // Data back and last write seen
    output logic [7:0]       q_out,
    output logic [15:0]      wr_addr_out,
    output logic             hi_drv_out
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  latch_q;
    logic [7:0]  last_q = 8'h00;
    logic [15:0] addr;
    // Latch follows the pins while strobe high, freezes when it falls
    always_latch if (ale_in) latch_q = ad_pins_in;
    // Undriven high lines fall back to the port latch value
    assign addr = {addr_hi_oe_in ? addr_hi_in : PORT_HI, mux_in ? latch_q : addr_lo_in};
    // Released data lines show the inverse of the last byte
    assign q_out = !rd_n_in ? mem[addr] : ~last_q;
    // Write while strobe low, remember the address used
    always @(posedge clk_in) begin
        if (!rd_n_in) last_q <= mem[addr];
        if (!wr_n_in) begin
            mem[addr] <= ad_pins_in;
            wr_addr_out <= addr;
            hi_drv_out <= addr_hi_oe_in;
        end
    end
endmodule : emi_sram_model

/* File: dv/ext_memory_interface_modes_bench.sv */
// Self-checking bench of the external memory interface controller
`timescale 1ns/10ps
module ext_memory_interface_modes_bench;
    logic clk, nrst, cfg_load, tm_load, req, wr, wide, mux;
    logic [7:0] cfg_byte, tm_byte, page, idx, wdata, ram_rdata, ad_in, q, rdata, rd_v;
    logic [7:0] cfg_rb, tm_rb, ad_out, hi, lo;
    logic [15:0] dptr, wr_addr;
    logic [12:0] ram_addr, ram_seen;
    logic busy, done, ram_en, hi_oe, lo_oe, ad_oe, ale, rd_n, wr_n, hi_drv;
    int fails = 0, check_count = 0, n;
    logic [7:0] cfgs [4] = '{8'h1c, 8'h0c, 8'h0f, 8'h19};
    logic [7:0] tms [4] = '{8'h00, 8'h00, 8'hff, 8'h99};

    emi_ctrl u_dut (.CLK_IN(clk), .NRST_IN(nrst), .CFG_LOAD_IN(cfg_load),
        .CFG_BYTE_IN(cfg_byte), .TIMING_LOAD_IN(tm_load), .TIMING_BYTE_IN(tm_byte),
        .PAGE_HIGH_BYTE_IN(page), .CFG_BYTE_OUT(cfg_rb), .TIMING_BYTE_OUT(tm_rb),
        .REQ_IN(req), .WRITE_IN(wr), .WIDE_IN(wide), .DPTR_IN(dptr), .INDEX_IN(idx),
        .WDATA_IN(wdata), .BUSY_OUT(busy), .DONE_OUT(done), .RDATA_OUT(rdata),
        .PHASE_OUT(), .RAM_EN_OUT(ram_en), .RAM_WE_OUT(), .RAM_ADDR_OUT(ram_addr),
        .RAM_WDATA_OUT(), .RAM_RDATA_IN(ram_rdata), .ADDR_HI_OUT(hi),
        .ADDR_HI_OE_OUT(hi_oe), .ADDR_LO_OUT(lo), .ADDR_LO_OE_OUT(lo_oe), .AD_IN(ad_in),
        .AD_OUT(ad_out), .AD_OE_OUT(ad_oe), .ALE_OUT(ale), .RD_N_OUT(rd_n), .WR_N_OUT(wr_n));
    emi_sram_model u_mem (.clk_in(clk), .mux_in(mux), .ale_in(ale), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .ad_pins_in(ad_out), .addr_hi_in(hi), .addr_hi_oe_in(hi_oe),
        .addr_lo_in(lo), .q_out(q), .wr_addr_out(wr_addr), .hi_drv_out(hi_drv));
    // Shared data wire: device drive wins while its enable is high
    assign ad_in = ad_oe ? ad_out : q;
    // On-chip RAM stand-in, one cycle read latency
    always @(posedge clk) if (ram_en) begin
        ram_rdata <= ram_addr[7:0] ^ 8'ha5;
        ram_seen <= ram_addr;
    end
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    task automatic setup(input logic [7:0] c, input logic [7:0] t);
        @(posedge clk);
        {cfg_load, tm_load, cfg_byte, tm_byte} <= {2'h3, c, t};
        @(posedge clk);
        {cfg_load, tm_load} <= 2'h0;
        mux <= !c[4];
    endtask : setup
    // One move; counts busy cycles up to the answer
    task automatic move(input logic w, input logic wd, input logic [15:0] a,
                        input logic [7:0] d);
        @(posedge clk);
        {req, wr, wide, dptr, page, idx, wdata} <= {1'b1, w, wd, a, a, d};
        @(posedge clk);
        req <= 1'b0;
        n = 0;
        for (int k = 0; k < 100; k++) begin
            @(negedge clk);
            if (busy === 1'b1) n++;
            if (done === 1'b1) break;
        end
        rd_v = rdata;
    endtask : move
    function automatic logic [15:0] lenf(input logic [7:0] c, input logic [7:0] t);
        return 16'h5 + t[7:6] + t[5:2] + t[1:0] + (c[4] ? 16'h0 : 16'h2 * (c[1:0] + 16'h1));
    endfunction : lenf

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {nrst, cfg_load, tm_load, req, wr, wide, mux} = 7'h0;
        {cfg_byte, tm_byte, page, idx, wdata, ram_rdata, dptr} = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check(cfg_rb, 16'h03);
        check(tm_rb, 16'hff);
        check({ale, rd_n, wr_n, hi_oe, lo_oe, ad_oe}, 16'h18);
        $display("test reset done");
        for (int t = 0; t < 4; t++) begin
            setup(cfgs[t], tms[t]);
            move(1'b1, 1'b1, 16'h3100 + 16'(t), 8'h50 + 8'(t));
            check(16'(n), lenf(cfgs[t], tms[t]));
            check(wr_addr, 16'h3100 + 16'(t));
            check(16'(hi_drv), 16'h1);
            move(1'b0, 1'b1, 16'h3100 + 16'(t), 8'h00);
            check(16'(n), lenf(cfgs[t], tms[t]));
            check(16'(rd_v), 16'h50 + 16'(t));
        end
        $display("test timing done");
        setup(8'h10, 8'h00);
        move(1'b0, 1'b1, 16'h2005, 8'h00);
        check(16'(n), 16'h2);
        check(16'(ram_seen), 16'h0005);
        check(16'(rd_v), 16'h00a0);
        move(1'b0, 1'b0, 16'h3344, 8'h00);
        check(16'(ram_seen), 16'h1344);
        $display("test internal done");
        setup(8'h14, 8'h00);
        move(1'b1, 1'b0, 16'h4021, 8'h77);
        check(16'(n), 16'h5);
        check(wr_addr, 16'h0021);
        check(16'(hi_drv), 16'h0);
        move(1'b0, 1'b1, 16'h1000, 8'h00);
        check(16'(n), 16'h2);
        move(1'b1, 1'b1, 16'h8000, 8'h66);
        check(wr_addr, 16'h8000);
        setup(8'h18, 8'h00);
        move(1'b1, 1'b0, 16'h4022, 8'h78);
        check(wr_addr, 16'h4022);
        check(16'(hi_drv), 16'h1);
        $display("test split done");
        setup(8'h1c, 8'h00);
        move(1'b1, 1'b0, 16'h0010, 8'h79);
        check(16'(n), 16'h5);
        move(1'b1, 1'b0, 16'h4011, 8'h7a);
        check(wr_addr, 16'h0011);
        check(16'(hi_drv), 16'h0);
        $display("test external done");
        conclude();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule : ext_memory_interface_modes_bench
